// File: hw/pma_defines.vh
`ifndef PMA_DEFINES_VH
`define PMA_DEFINES_VH
// register byte addresses
`define PMA_CTRL_ADDR      8'h00
`define PMA_STATUS_ADDR    8'h04
`define PMA_IRQ_STAT_ADDR  8'h08
`define PMA_IRQ_MASK_ADDR  8'h0c
`define PMA_CFG_ADDR       8'h10
// control register fields
`define PMA_ZC_SYNC_BIT    11
`define PMA_ASYNC_BIT      14
`define PMA_CLKSEL_LO      15
`define PMA_CLKSEL_HI      16
`define PMA_CTRL_RESET     32'h00004000
`define PMA_CTRL_MASK      32'h0001c800
// clock select codes
`define PMA_CLK_DIV1       2'h0
`define PMA_CLK_DIV2       2'h1
`define PMA_CLK_DIV4       2'h2
// irq status / mask bit positions
`define PMA_EV_WDOG        0
`define PMA_EV_CORRUPT     1
`define PMA_EV_THERMAL     2
`define PMA_EV_PGOOD       3
`define PMA_EV_TXLIMIT     4
`define PMA_EV_ZCPOS       5
`define PMA_EV_WIDTH       6
// timing
`define PMA_CLK_MHZ        100
`define PMA_RESET_PULSE_US 1000
`define PMA_RESET_CYCLES   (`PMA_RESET_PULSE_US * `PMA_CLK_MHZ)
`define PMA_WDOG_MS        1500
`define PMA_WDOG_CYCLES    (`PMA_WDOG_MS * 1000 * `PMA_CLK_MHZ)
`define PMA_TXHOLD_MS      125
`define PMA_TXHOLD_CYCLES  (`PMA_TXHOLD_MS * 1000 * `PMA_CLK_MHZ)
`define PMA_OSC_START_CYC  16
`endif

// File: hw/pma_sync_edge.v
// two-stage synchroniser with edge detection on the second stage
module pma_sync_edge (
    input  wire core_clk,    // clock
    input  wire sys_rst,     // sync reset
    input  wire din,         // raw input
    output reg  level,       // synchronised level
    output wire rise,        // rising edge pulse
    output wire fall         // falling edge pulse
);
    reg stage1;
    reg levelD;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            stage1 <= 1'b1;
            level  <= 1'b1;
            levelD <= 1'b1;
        end else begin
            stage1 <= din;
            level  <= stage1;
            levelD <= level;
        end
    end

    assign rise = level & ~levelD;
    assign fall = ~level & levelD;
endmodule // pma_sync_edge

// File: hw/pma_clk_div.v
`include "pma_defines.vh"
// master clock divider, selection taken only at period end
module pma_clk_div (
    input  wire       core_clk,    // clock
    input  wire       sys_rst,     // sync reset
    input  wire [1:0] sel,         // requested ratio
    output reg        mclkOut      // divided clock
);
    reg [1:0] activeSel;
    reg [2:0] phase;
    wire      periodEnd;
    wire      lowPoint;

    // period of 2, 4 or 8 cycles, high in its first half
    assign periodEnd = (activeSel == `PMA_CLK_DIV1) ? phase[0] :
                       (activeSel == `PMA_CLK_DIV2) ? (phase[1:0] == 2'h3) :
                       (phase == 3'h7);
    assign lowPoint  = (activeSel == `PMA_CLK_DIV1) ? (phase == 3'h0) :
                       (activeSel == `PMA_CLK_DIV2) ? (phase == 3'h1) :
                       (phase == 3'h3);

    always @(posedge core_clk) begin
        if (sys_rst) begin
            activeSel <= `PMA_CLK_DIV4;
            phase     <= 3'h0;
            mclkOut   <= 1'b0;
        end else begin
            if (periodEnd) begin
                // switch only at the end of a whole period
                activeSel <= (sel == 2'h3) ? activeSel : sel; // see [R11]
                phase     <= 3'h0;
                mclkOut   <= 1'b1;                           // see [R10]
            end else begin
                phase <= phase + 3'h1;
                if (lowPoint)
                    mclkOut <= 1'b0;                         // see [R10]
            end
        end
    end
endmodule // pma_clk_div

// File: hw/pma_aux_top.v
// Functional notes
// [R1] app reset output held low during startup sequence.
// [R2] reset output rises a fixed delay after oscillator startup ends.
// [R3] watchdog expiry resets internally and pulses reset low same delay.
// [R4] host pulses watchdog kick input low before expiry.
// [R5] mains phase output follows positive and negative zero-crossings.
// [R6] control bit 11 aligns transmit start to positive zero-crossing.
// [R7] sync transmit enables line interface, holds bit clock until crossing.
// [R8] zero-crossing sync works only in synchronous interface mode.
// [R9] async mode host watches mains phase output itself.
// [R10] master clock selectable as full, half or quarter rate; code gives core clock /2, /4 or /8.
// [R11] clock selection change waits for current period end.
// [R12] corruption flag set when stored control contents corrupted.
// [R13] corruption checking suppressed during a control write session.
// [R14] over-temperature switches the line interface off.
// [R15] transmit limit flag high while over-temperature persists, unlatched.
// [R16] power good low at startup, follows supply with hysteresis.
// [R17] transmit expiry raises limit flag, held at least minimum time.
// [R18] reset delay and watchdog period are parameterised cycle counts.
// [R19] watchdog kick synchronised and falling edge detected.
`include "pma_defines.vh"
module pma_aux_top #(
    parameter RESET_CYCLES  = `PMA_RESET_CYCLES,
    parameter WDOG_CYCLES   = `PMA_WDOG_CYCLES,
    parameter TXHOLD_CYCLES = `PMA_TXHOLD_CYCLES
) (
    input  wire        core_clk,          // 100 MHz clock
    input  wire        sys_rst,           // sync reset, active high
    input  wire [31:0] haddr,             // ahb address
    input  wire [1:0]  htrans,            // ahb transfer type
    input  wire        hwrite,            // ahb write
    input  wire [2:0]  hsize,             // ahb size
    input  wire [31:0] hwdata,            // ahb write data
    input  wire        hsel,              // ahb select
    input  wire        hready,            // ahb bus ready
    output reg  [31:0] hrdata,            // ahb read data
    output wire        hreadyout,         // ahb slave ready
    output wire        hresp,             // ahb response
    input  wire        watchdog_kick_in,  // host kick, active low pulse
    input  wire        mains_sense_in,    // zero-crossing comparator
    input  wire        rx_tx_select,      // 1 rx, 0 tx
    input  wire        bit_clock_in,      // raw bit clock from modem
    input  wire        over_temp_in,      // thermal shutdown indication
    input  wire        supply_above_in,   // supply above good threshold
    input  wire        supply_below_in,   // supply below threshold minus hyst
    input  wire        tx_expired_in,     // transmit duration expiry pulse
    output reg         app_reset_out,     // application reset, low active
    output wire        internal_reset,    // internal reset request
    output reg         mains_phase_out,   // mains phase
    output reg         bit_clock_out,     // gated bit clock
    output reg         line_interface,    // line interface enable
    output reg         config_corrupt_flag, // control corrupted
    output reg         tx_limit_flag_pin, // transmit limit flag
    output reg         power_good,        // power good
    output wire        mclk_out,          // master clock
    output wire        irq                // level interrupt
);
    reg  [31:0] ctrl;
    reg  [31:0] ctrlShadow;
    reg  [`PMA_EV_WIDTH-1:0] irqStat;
    reg  [`PMA_EV_WIDTH-1:0] irqMask;
    reg         writeSession;
    reg  [31:0] rstCnt;
    reg  [31:0] wdogCnt;
    reg  [31:0] holdCnt;
    reg  [4:0]  oscCnt;
    reg         oscDone;
    reg         wdogFire;
    reg         dataPhase;
    reg         dataWrite;
    reg  [7:0]  dataAddr;
    reg  [2:0]  txState;
    reg         zcSeen;
    reg         thermalD;
    reg         pgoodD;
    reg         txFlagD;
    wire        kickFall;
    wire        zcLevel;
    wire        zcRise;
    wire        zcFall;
    wire        syncMode;
    wire        corruptNow;
    wire [`PMA_EV_WIDTH-1:0] evSet;
    wire        statRead;

    localparam TX_IDLE = 3'b001;
    localparam TX_WAIT = 3'b010;
    localparam TX_RUN  = 3'b100;

    pma_sync_edge uKick (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (watchdog_kick_in),
        .level    (),
        .rise     (),
        .fall     (kickFall)              // see [R19]
    );

    pma_sync_edge uZc (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (mains_sense_in),
        .level    (zcLevel),
        .rise     (zcRise),
        .fall     (zcFall)
    );

    pma_clk_div uMclk (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .sel      (ctrl[`PMA_CLKSEL_HI:`PMA_CLKSEL_LO]),
        .mclkOut  (mclk_out)
    );

    // ahb-lite slave, zero wait states
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            dataPhase <= 1'b0;
            dataWrite <= 1'b0;
            dataAddr  <= 8'h00;
        end else if (hready) begin
            dataPhase <= hsel & htrans[1];
            dataWrite <= hsel & htrans[1] & hwrite;
            dataAddr  <= haddr[7:0];
        end
    end

    assign statRead = hready & hsel & htrans[1] & ~hwrite &
                      (haddr[7:0] == `PMA_IRQ_STAT_ADDR);

    always @(posedge core_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
        end else if (hready & hsel & htrans[1] & ~hwrite) begin
            case (haddr[7:0])
                `PMA_CTRL_ADDR:     hrdata <= ctrl;
                `PMA_STATUS_ADDR:   hrdata <= {25'h0, app_reset_out, power_good,
                                      tx_limit_flag_pin, config_corrupt_flag,
                                      line_interface, mains_phase_out, writeSession};
                `PMA_IRQ_STAT_ADDR: hrdata <= {26'h0, irqStat};
                `PMA_IRQ_MASK_ADDR: hrdata <= {26'h0, irqMask};
                `PMA_CFG_ADDR:      hrdata <= {31'h0, writeSession};
                default:            hrdata <= 32'h00000000;
            endcase
        end
    end

    // control register and shadow copy for integrity check
    always @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl         <= `PMA_CTRL_RESET;
            ctrlShadow   <= `PMA_CTRL_RESET;
            irqMask      <= 6'h00;
            writeSession <= 1'b0;
        end else if (dataPhase & dataWrite) begin
            case (dataAddr)
                `PMA_CTRL_ADDR: begin
                    ctrl       <= hwdata & `PMA_CTRL_MASK;
                    ctrlShadow <= hwdata & `PMA_CTRL_MASK;
                end
                `PMA_IRQ_MASK_ADDR: irqMask      <= hwdata[`PMA_EV_WIDTH-1:0];
                `PMA_CFG_ADDR:      writeSession <= hwdata[0];
                default: ;
            endcase
        end
    end

    assign corruptNow = (ctrl != ctrlShadow) & ~writeSession;   // see [R13]

    always @(posedge core_clk) begin
        if (sys_rst) begin
            config_corrupt_flag <= 1'b0;
        end else if (corruptNow) begin
            config_corrupt_flag <= 1'b1;                         // see [R12]
        end else if (dataPhase & dataWrite & (dataAddr == `PMA_CTRL_ADDR)) begin
            config_corrupt_flag <= 1'b0;
        end
    end

    // oscillator startup, reset generator and watchdog
    always @(posedge core_clk) begin
        if (sys_rst) begin
            oscCnt        <= 5'h00;
            oscDone       <= 1'b0;
            rstCnt        <= 32'h00000000;
            app_reset_out <= 1'b0;                               // see [R1]
            wdogCnt       <= 32'h00000000;
            wdogFire      <= 1'b0;
        end else begin
            wdogFire <= 1'b0;
            if (!oscDone) begin
                oscCnt  <= oscCnt + 5'h01;
                oscDone <= (oscCnt == `PMA_OSC_START_CYC - 1);
            end else if (!app_reset_out) begin
                if (rstCnt == RESET_CYCLES - 1) begin          // see [R2] [R18]
                    app_reset_out <= 1'b1;
                    rstCnt        <= 32'h00000000;
                    wdogCnt       <= 32'h00000000;
                end else begin
                    rstCnt <= rstCnt + 32'h00000001;
                end
            end else if (kickFall) begin
                wdogCnt <= 32'h00000000;
            end else if (wdogCnt == WDOG_CYCLES - 1) begin     // see [R3] [R18]
                app_reset_out <= 1'b0;
                wdogFire      <= 1'b1;
                wdogCnt       <= 32'h00000000;
            end else begin
                wdogCnt <= wdogCnt + 32'h00000001;
            end
        end
    end

    assign internal_reset = ~app_reset_out;                      // see [R3]

    // mains phase and power good
    always @(posedge core_clk) begin
        if (sys_rst) begin
            mains_phase_out <= 1'b0;
            power_good      <= 1'b0;                             // see [R16]
        end else begin
            if (zcRise)
                mains_phase_out <= 1'b1;                         // see [R5]
            else if (zcFall)
                mains_phase_out <= 1'b0;
            if (supply_above_in)
                power_good <= 1'b1;                              // see [R16]
            else if (supply_below_in)
                power_good <= 1'b0;
        end
    end

    // transmit start alignment
    assign syncMode = ctrl[`PMA_ZC_SYNC_BIT] & ~ctrl[`PMA_ASYNC_BIT]; // see [R6] [R8]

    always @(posedge core_clk) begin
        if (sys_rst) begin
            txState        <= TX_IDLE;
            zcSeen         <= 1'b0;
            line_interface <= 1'b0;
            bit_clock_out  <= 1'b0;
        end else begin
            case (txState)
                TX_IDLE: begin
                    zcSeen        <= 1'b0;
                    bit_clock_out <= bit_clock_in;
                    if (!rx_tx_select)
                        txState <= syncMode ? TX_WAIT : TX_RUN;
                end
                TX_WAIT: begin
                    bit_clock_out <= 1'b0;                       // see [R7]
                    if (rx_tx_select)
                        txState <= TX_IDLE;
                    else if (zcRise) begin
                        zcSeen  <= 1'b1;
                        txState <= TX_RUN;
                    end
                end
                TX_RUN: begin
                    bit_clock_out <= bit_clock_in;
                    if (rx_tx_select)
                        txState <= TX_IDLE;
                end
                default: txState <= TX_IDLE;
            endcase
            // line on in transmit unless overheated
            line_interface <= ~rx_tx_select & ~over_temp_in;      // see [R7] [R14]
        end
    end

    // transmit limit flag: thermal level or held expiry
    always @(posedge core_clk) begin
        if (sys_rst) begin
            holdCnt           <= 32'h00000000;
            tx_limit_flag_pin <= 1'b0;
        end else begin
            if (tx_expired_in)
                holdCnt <= TXHOLD_CYCLES;                        // see [R17]
            else if (holdCnt != 32'h00000000)
                holdCnt <= holdCnt - 32'h00000001;
            tx_limit_flag_pin <= over_temp_in | tx_expired_in |
                                 (holdCnt != 32'h00000000);      // see [R15] [R17]
        end
    end

    // interrupt status: set wins over read-clear
    always @(posedge core_clk) begin
        if (sys_rst) begin
            thermalD <= 1'b0;
            pgoodD   <= 1'b0;
            txFlagD  <= 1'b0;
        end else begin
            thermalD <= over_temp_in;
            pgoodD   <= power_good;
            txFlagD  <= tx_expired_in;
        end
    end

    assign evSet = {zcRise, tx_expired_in & ~txFlagD, power_good ^ pgoodD,
                    over_temp_in & ~thermalD, corruptNow, wdogFire};

    always @(posedge core_clk) begin
        if (sys_rst)
            irqStat <= 6'h00;
        else
            irqStat <= (statRead ? 6'h00 : irqStat) | evSet;
    end

    assign irq = |(irqStat & irqMask);
endmodule // pma_aux_top

// File: test/pma_aux_properties.sv
module pma_aux_properties #(
    parameter RESET_CYCLES  = 20,
    parameter TXHOLD_CYCLES = 50
) (
    input wire core_clk,          // clock
    input wire sys_rst,           // reset
    input wire hreadyout,         // slave ready
    input wire hresp,             // response
    input wire mains_sense_in,    // mains
    input wire over_temp_in,      // hot
    input wire supply_above_in,   // supply high
    input wire supply_below_in,   // supply low
    input wire tx_expired_in,     // tx expiry
    input wire app_reset_out,     // app reset
    input wire internal_reset,    // int reset
    input wire mains_phase_out,   // phase
    input wire line_interface,    // line on
    input wire tx_limit_flag_pin, // limit flag
    input wire power_good,        // pgood
    input wire mclk_out           // mclk
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    integer lowCnt;
    integer expCnt;
    integer runLen;
    reg     prevM;
    reg     seenEdge;
    always @(posedge core_clk) begin
        prevM <= mclk_out;
        if (sys_rst) begin
            lowCnt   <= 0;
            expCnt   <= TXHOLD_CYCLES;
            runLen   <= 0;
            seenEdge <= 1'b0;
        end else begin
            lowCnt <= app_reset_out ? 0 : lowCnt + 1;
            if (tx_expired_in)
                expCnt <= 0;
            else if (expCnt < TXHOLD_CYCLES)
                expCnt <= expCnt + 1;
            runLen <= (mclk_out != prevM) ? 1 : runLen + 1;
            if (mclk_out != prevM)
                seenEdge <= 1'b1;
        end
    end
    a_reset_startup: assert property ($fell(sys_rst) |-> !app_reset_out [*8])
        else $error("app reset not low after startup");
    a_reset_width: assert property ($rose(app_reset_out) |->
        lowCnt >= RESET_CYCLES && lowCnt <= RESET_CYCLES + 24)
        else $error("app reset low time wrong");
    a_int_mirror: assert property (internal_reset == !app_reset_out)
        else $error("internal reset disagrees");
    a_phase_high: assert property ((mains_sense_in && app_reset_out) [*5] |->
        mains_phase_out)
        else $error("phase not high");
    a_phase_low: assert property ((!mains_sense_in && app_reset_out) [*5] |->
        !mains_phase_out)
        else $error("phase not low");
    a_hot_line: assert property (over_temp_in |=> !line_interface)
        else $error("line on while hot");
    a_hot_flag: assert property (over_temp_in [*3] |-> tx_limit_flag_pin)
        else $error("limit flag low while hot");
    a_flag_hold: assert property ($fell(tx_limit_flag_pin) |->
        expCnt >= TXHOLD_CYCLES - 1)
        else $error("limit flag dropped early");
    a_pgood_up: assert property (supply_above_in [*3] |-> power_good)
        else $error("power good low");
    a_pgood_band: assert property ((!supply_above_in && !supply_below_in) [*3] |=>
        $stable(power_good))
        else $error("power good moved in band");
    a_mclk_ratio: assert property (($changed(mclk_out) && seenEdge) |->
        (runLen == 1 || runLen == 2 || runLen == 4))
        else $error("mclk half period wrong");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error");
    c_reset_rise: cover property ($rose(app_reset_out));
    c_flag_fall: cover property ($fell(tx_limit_flag_pin));
    c_phase_rise: cover property ($rose(mains_phase_out));
endmodule // pma_aux_properties

bind pma_aux_top pma_aux_properties #(.RESET_CYCLES(RESET_CYCLES),
    .TXHOLD_CYCLES(TXHOLD_CYCLES)) u_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .hreadyout(hreadyout), .hresp(hresp), .mains_sense_in(mains_sense_in),
    .over_temp_in(over_temp_in), .supply_above_in(supply_above_in),
    .supply_below_in(supply_below_in), .tx_expired_in(tx_expired_in),
    .app_reset_out(app_reset_out), .internal_reset(internal_reset),
    .mains_phase_out(mains_phase_out), .line_interface(line_interface),
    .tx_limit_flag_pin(tx_limit_flag_pin), .power_good(power_good), .mclk_out(mclk_out));

// File: test/pma_host_model.sv
module pma_host_model #(
    parameter KICK_PERIOD = 60
) (
    input  wire core_clk,                // clock
    input  wire sys_rst,                 // reset
    input  wire kickEnable,              // keep kicking
    input  wire txReq,                   // want to send
    input  wire alignTx,                 // wait for phase rise
    input  wire mains_phase_out,         // phase
    output reg  watchdog_kick_in = 1'b1, // kick, low pulse
    output reg  rx_tx_select = 1'b1      // 0 tx
);
    timeunit 1ns;
    timeprecision 1ns;
    integer kickCnt = 0;
    reg     lastPhase = 1'b0;
    always @(posedge core_clk) begin
        lastPhase <= mains_phase_out;
        if (sys_rst || !kickEnable) begin
            kickCnt          <= 0;
            watchdog_kick_in <= 1'b1;
        end else begin
            kickCnt          <= (kickCnt == KICK_PERIOD) ? 0 : kickCnt + 1;
            watchdog_kick_in <= (kickCnt > 3);
        end
        if (sys_rst || !txReq)
            rx_tx_select <= 1'b1;
        else if (!alignTx || (mains_phase_out && !lastPhase))
            rx_tx_select <= 1'b0;
    end
endmodule // pma_host_model

// File: test/pma_testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam RST = 20;
    localparam TXH = 50;
    reg         core_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [31:0] haddr = 32'h0;
    reg  [31:0] hwdata = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg         hwrite = 1'b0, hsel = 1'b0, mainsIn = 1'b0, bitClk = 1'b0, hot = 1'b0;
    reg         supAbove = 1'b0, supBelow = 1'b0, txExp = 1'b0, kickEn = 1'b1;
    reg         txReq = 1'b0, alignTx = 1'b0, m;
    reg  [31:0] rd;
    wire [31:0] hrdata;
    wire        hreadyout, hresp, kickN, rxSel, appRst, phase, bitOut, lineOn;
    wire        corrupt, limitFlag, pgood, mclk, irq;
    integer     miscompares = 0, checks_done = 0, n, i;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) bitClk <= ~bitClk;

    pma_aux_top #(.RESET_CYCLES(RST), .WDOG_CYCLES(200), .TXHOLD_CYCLES(TXH)) DUT (
        .core_clk(core_clk), .sys_rst(sys_rst), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .watchdog_kick_in(kickN),
        .mains_sense_in(mainsIn), .rx_tx_select(rxSel), .bit_clock_in(bitClk),
        .over_temp_in(hot), .supply_above_in(supAbove), .supply_below_in(supBelow),
        .tx_expired_in(txExp), .app_reset_out(appRst), .internal_reset(),
        .mains_phase_out(phase), .bit_clock_out(bitOut), .line_interface(lineOn),
        .config_corrupt_flag(corrupt), .tx_limit_flag_pin(limitFlag),
        .power_good(pgood), .mclk_out(mclk), .irq(irq));

    pma_host_model u_host (.core_clk(core_clk), .sys_rst(sys_rst), .kickEnable(kickEn),
        .txReq(txReq), .alignTx(alignTx), .mains_phase_out(phase),
        .watchdog_kick_in(kickN), .rx_tx_select(rxSel));

    task cyc(input integer k);
        repeat (k) @(posedge core_clk);
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task waitRdy;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
    endtask
    task xfer(input w, input [31:0] a, input [31:0] d);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsel <= 1'b1;
        waitRdy;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        waitRdy;
        rd = hrdata;
    endtask
    task pulseOr(input integer k);
        n = 0;
        repeat (k) begin
            cyc(1);
            n = n | bitOut;
        end
    endtask
    task results;
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #60000;
        miscompares = miscompares + 1;
        results;
    end

    initial begin
        cyc(2);
        sys_rst <= 1'b0;
        cyc(2);
        check(appRst, 0);
        n = 1;
        while (appRst !== 1'b1 && n < 200) begin
            cyc(1);
            n = n + 1;
        end
        check(n >= RST + 16 && n <= RST + 24, 1);
        xfer(0, 32'h0, 32'h0);
        check(rd, 32'h4000);
        xfer(0, 32'h20, 32'h0);
        check(rd, 32'h0);
        mainsIn <= 1'b1;
        cyc(6);
        check(phase, 1);
        mainsIn <= 1'b0;
        cyc(6);
        check(phase, 0);
        txReq <= 1'b1;
        xfer(1, 32'h0c, 32'h0);
        xfer(0, 32'h08, 32'h0);
        check(lineOn, 1);
        hot <= 1'b1;
        cyc(4);
        check({lineOn, limitFlag, irq}, 3'b010);
        hot <= 1'b0;
        cyc(4);
        check({lineOn, limitFlag}, 2'b10);
        xfer(0, 32'h08, 32'h0);
        check(rd & 32'h4, 32'h4);
        xfer(1, 32'h0c, 32'h4);
        hot <= 1'b1;
        cyc(4);
        hot <= 1'b0;
        cyc(4);
        check(irq, 1);
        xfer(0, 32'h08, 32'h0);
        cyc(1);
        check(irq, 0);
        txReq <= 1'b0;
        xfer(1, 32'h0, 32'h800);
        txReq <= 1'b1;
        cyc(3);
        check(lineOn, 1);
        pulseOr(10);
        check(n, 0);
        mainsIn <= 1'b1;
        pulseOr(12);
        check(n, 1);
        txReq <= 1'b0;
        mainsIn <= 1'b0;
        xfer(1, 32'h0, 32'h4800);
        txReq <= 1'b1;
        cyc(3);
        pulseOr(10);
        check(n, 1);
        txReq <= 1'b0;
        cyc(4);
        alignTx <= 1'b1;
        txReq <= 1'b1;
        cyc(5);
        check(rxSel, 1);
        mainsIn <= 1'b1;
        cyc(8);
        check(rxSel, 0);
        txReq <= 1'b0;
        alignTx <= 1'b0;
        for (i = 0; i < 3; i = i + 1) begin
            xfer(1, 32'h0, 32'h4000 | (i << 15));
            cyc(12);
            m = mclk;
            while (mclk === m) cyc(1);
            m = mclk;
            n = 0;
            while (mclk === m && n < 10) begin
                cyc(1);
                n = n + 1;
            end
            check(n, 1 << i);
        end
        for (i = 0; i < 4; i = i + 1) begin
            {supAbove, supBelow} <= 2'(12'b101_001_010_000 >> (10 - 3 * i));
            cyc(5);
            check(pgood, (12'b101_001_010_000 >> (9 - 3 * i)) & 1);
        end
        txExp <= 1'b1;
        cyc(1);
        txExp <= 1'b0;
        cyc(TXH);
        check(limitFlag, 1);
        cyc(20);
        check(limitFlag, 0);
        xfer(1, 32'h10, 32'h1);
        xfer(1, 32'h0, 32'h4000);
        xfer(1, 32'h10, 32'h0);
        check(corrupt, 0);
        check(appRst, 1);
        kickEn <= 1'b0;
        n = 0;
        while (appRst === 1'b1 && n < 400) begin
            cyc(1);
            n = n + 1;
        end
        check(n > 130 && n < 400, 1);
        kickEn <= 1'b1;
        n = 0;
        while (appRst !== 1'b1 && n < 200) begin
            cyc(1);
            n = n + 1;
        end
        check(n >= RST && n <= RST + 24, 1);
        results;
    end
endmodule // testbench
